// file: shared/isbo_pkg.sv
// Notes on behaviour
// - Decrement-skip writes f minus one, flags untouched
// - Destination select 0 is working, 1 file
// - Zero decrement result turns next instruction into nop
// - Increment-skip adds one, flags untouched, zero skips
// - Plain increment writes f plus one, updates zero
// - Branch loads eleven-bit operand into low counter bits
// - Branch copies page latch bits 4:3 to 12:11
// - Branch takes two cycles, flags untouched
// - Literal OR into working register, updates zero
// - OR working with file, routed result, updates zero
`default_nettype none
package isbo_pkg;
    // ------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned PC_W      = 13;
    localparam int unsigned LIT_W     = 11;
    localparam int unsigned ADDR_W    = 7;
    localparam int unsigned PAGE_HI   = 4;
    localparam int unsigned PAGE_LO   = 3;
    localparam int unsigned PC_PAGE_HI = 12;
    localparam int unsigned PC_PAGE_LO = 11;
    localparam int unsigned LIT8_HI   = 7;

    // ------------------------------------------------------------
    // Reset values and constants
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] W_RESET    = 8'h00;
    localparam logic              Z_RESET    = 1'b0;
    localparam logic [PC_W-1:0]   PC_RESET   = 13'h0000;
    localparam logic [PC_W-1:0]   PC_STEP    = 13'h0001;
    localparam logic [DATA_W-1:0] DATA_ONE   = 8'h01;
    localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;
    localparam logic              DEST_WORK  = 1'b0;
    localparam logic              DEST_FILE  = 1'b1;

    // ------------------------------------------------------------
    // Decoded operations and sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        op_none                   = 3'b000,
        op_decrement_skip_if_zero = 3'b001,
        op_increment_skip_if_zero = 3'b010,
        op_increment_file         = 3'b011,
        op_unconditional_branch   = 3'b100,
        op_or_literal_into_working = 3'b101,
        op_or_working_with_file   = 3'b110
    } isbo_op_t;

    typedef enum logic {
        st_exec    = 1'b0,
        st_discard = 1'b1
    } isbo_state_t;
endpackage
`default_nettype wire

// file: shared/isbo_alu_if.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Operands and result between sequencer and data path
// ------------------------------------------------------------
interface isbo_alu_if;
    isbo_pkg::isbo_op_t              op;
    logic [isbo_pkg::DATA_W-1:0]     file_val;
    logic [isbo_pkg::DATA_W-1:0]     work_val;
    logic [isbo_pkg::DATA_W-1:0]     literal;
    logic [isbo_pkg::DATA_W-1:0]     result;
    logic                            result_zero;
    logic                            writes_zero;
    logic                            wants_skip;

    modport seq (output op, file_val, work_val, literal,
                 input result, result_zero, writes_zero, wants_skip);
    modport alu (input op, file_val, work_val, literal,
                 output result, result_zero, writes_zero, wants_skip);
endinterface
`default_nettype wire

// file: logic/isbo_alu.sv
`timescale 1ns/100ps
`default_nettype none
module isbo_alu
(
    isbo_alu_if.alu bus
);
    // ------------------------------------------------------------
    // Result selection, purely combinational
    // ------------------------------------------------------------
    // Sized adds drop the carry out, so 8'hff + 1 wraps to 0
    always_comb
    begin
        bus.result      = isbo_pkg::DATA_ZERO;
        bus.writes_zero = 1'b0;
        bus.wants_skip  = 1'b0;
        case (bus.op)
            isbo_pkg::op_decrement_skip_if_zero:
            begin
                bus.result     = bus.file_val - isbo_pkg::DATA_ONE;
                bus.wants_skip = 1'b1;
            end
            isbo_pkg::op_increment_skip_if_zero:
            begin
                bus.result     = bus.file_val + isbo_pkg::DATA_ONE;
                bus.wants_skip = 1'b1;
            end
            isbo_pkg::op_increment_file:
            begin
                bus.result      = bus.file_val + isbo_pkg::DATA_ONE;
                bus.writes_zero = 1'b1;
            end
            isbo_pkg::op_or_literal_into_working:
            begin
                bus.result      = bus.work_val | bus.literal;
                bus.writes_zero = 1'b1;
            end
            isbo_pkg::op_or_working_with_file:
            begin
                bus.result      = bus.work_val | bus.file_val;
                bus.writes_zero = 1'b1;
            end
            default:
            begin
                bus.result = isbo_pkg::DATA_ZERO;
            end
        endcase
    end

    // Zero detect shared by the flag and the skip decision
    assign bus.result_zero = (bus.result == isbo_pkg::DATA_ZERO);
endmodule // isbo_alu
`default_nettype wire

// file: logic/isbo_exec.sv
`timescale 1ns/100ps
`default_nettype none
module isbo_exec
(
    input  wire logic                            core_clk,
    input  wire logic                            rst_n,
    input  wire logic                            instr_valid,
    input  wire isbo_pkg::isbo_op_t              instr_op,
    input  wire logic                            instr_dest,
    input  wire logic [isbo_pkg::ADDR_W-1:0]     instr_addr,
    input  wire logic [isbo_pkg::LIT_W-1:0]      instr_literal,
    input  wire logic [isbo_pkg::DATA_W-1:0]     file_rd_data,
    input  wire logic [isbo_pkg::DATA_W-1:0]     program_counter_page_latch,
    output wire logic [isbo_pkg::ADDR_W-1:0]     file_rd_addr,
    output wire logic                            nop_slot,
    output var  logic                            file_wr_en_r,
    output var  logic [isbo_pkg::ADDR_W-1:0]     file_wr_addr_r,
    output var  logic [isbo_pkg::DATA_W-1:0]     file_wr_data_r,
    output var  logic [isbo_pkg::DATA_W-1:0]     work_reg_r,
    output var  logic                            zero_flag_r,
    output var  logic [isbo_pkg::PC_W-1:0]       pc_r
);
    // ------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------
    isbo_alu_if alu_bus ();

    isbo_alu u_alu
    (
        .bus (alu_bus.alu)
    );

    isbo_pkg::isbo_state_t           state_r;
    isbo_pkg::isbo_state_t           state_nxt;
    logic                            file_wr_en_nxt;
    logic [isbo_pkg::ADDR_W-1:0]     file_wr_addr_nxt;
    logic [isbo_pkg::DATA_W-1:0]     file_wr_data_nxt;
    logic [isbo_pkg::DATA_W-1:0]     work_reg_nxt;
    logic                            zero_flag_nxt;
    logic [isbo_pkg::PC_W-1:0]       pc_nxt;
    logic                            execute;
    logic                            has_dest;
    logic                            skip_pending_r;
    logic                            skip_pending_nxt;

    // Operands go straight to the data path; file read is same cycle
    assign alu_bus.op       = instr_op;
    assign alu_bus.file_val = file_rd_data;
    assign alu_bus.work_val = work_reg_r;
    assign alu_bus.literal  = instr_literal[isbo_pkg::LIT8_HI:0];
    assign file_rd_addr     = instr_addr;

    // A word offered during the discard slot is swallowed as a nop
    assign nop_slot = (state_r == isbo_pkg::st_discard);
    assign execute  = instr_valid && !nop_slot;
    assign has_dest = (instr_op != isbo_pkg::op_unconditional_branch)
                   && (instr_op != isbo_pkg::op_or_literal_into_working)
                   && (instr_op != isbo_pkg::op_none);

    // ------------------------------------------------------------
    // Next-state computation
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt        = isbo_pkg::st_exec;
        file_wr_en_nxt   = 1'b0;
        file_wr_addr_nxt = file_wr_addr_r;
        file_wr_data_nxt = file_wr_data_r;
        work_reg_nxt     = work_reg_r;
        zero_flag_nxt    = zero_flag_r;
        pc_nxt           = pc_r;
        case (state_r)
            isbo_pkg::st_exec:
            begin
                if (execute)
                begin
                    pc_nxt = pc_r + isbo_pkg::PC_STEP;
                    if (instr_op == isbo_pkg::op_unconditional_branch)
                    begin
                        // Fetched successor is stale, so drop it
                        pc_nxt = {program_counter_page_latch[
                                      isbo_pkg::PAGE_HI:isbo_pkg::PAGE_LO],
                                  instr_literal};
                        state_nxt = isbo_pkg::st_discard;
                    end
                    else if (has_dest && instr_dest == isbo_pkg::DEST_FILE)
                    begin
                        file_wr_en_nxt   = 1'b1;
                        file_wr_addr_nxt = instr_addr;
                        file_wr_data_nxt = alu_bus.result;
                    end
                    else if (instr_op != isbo_pkg::op_none)
                    begin
                        work_reg_nxt = alu_bus.result;
                    end
                    // Skip forms leave the flag alone
                    if (alu_bus.writes_zero)
                    begin
                        zero_flag_nxt = alu_bus.result_zero;
                    end
                    if (alu_bus.wants_skip && alu_bus.result_zero)
                    begin
                        state_nxt = isbo_pkg::st_discard;
                    end
                end
            end
            isbo_pkg::st_discard:
            begin
                // Skipped word still occupies an address; branch does not
                if (instr_valid)
                begin
                    state_nxt = isbo_pkg::st_exec;
                    if (skip_pending_r)
                    begin
                        pc_nxt = pc_r + isbo_pkg::PC_STEP;
                    end
                end
                else
                begin
                    state_nxt = isbo_pkg::st_discard;
                end
            end
            default:
            begin
                state_nxt = isbo_pkg::st_exec;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Remember whether the slot came from a skip, to step past it
    always_comb
    begin
        skip_pending_nxt = skip_pending_r;
        if (execute)
        begin
            skip_pending_nxt = alu_bus.wants_skip;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r        <= isbo_pkg::st_exec;
            file_wr_en_r   <= 1'b0;
            file_wr_addr_r <= '0;
            file_wr_data_r <= isbo_pkg::DATA_ZERO;
            work_reg_r     <= isbo_pkg::W_RESET;
            zero_flag_r    <= isbo_pkg::Z_RESET;
            pc_r           <= isbo_pkg::PC_RESET;
            skip_pending_r <= 1'b0;
        end
        else
        begin
            state_r        <= state_nxt;
            file_wr_en_r   <= file_wr_en_nxt;
            file_wr_addr_r <= file_wr_addr_nxt;
            file_wr_data_r <= file_wr_data_nxt;
            work_reg_r     <= work_reg_nxt;
            zero_flag_r    <= zero_flag_nxt;
            skip_pending_r <= skip_pending_nxt;
            pc_r           <= pc_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence dec_hits_zero_s;
        execute && instr_op == isbo_pkg::op_decrement_skip_if_zero
        && file_rd_data == isbo_pkg::DATA_ONE;
    endsequence

    sequence inc_hits_zero_s;
        execute && instr_op == isbo_pkg::op_increment_skip_if_zero
        && file_rd_data == 8'hff;
    endsequence

    sequence branch_taken_s;
        execute && instr_op == isbo_pkg::op_unconditional_branch;
    endsequence

    dec_skip_slot_a: assert property (
        dec_hits_zero_s |=> nop_slot ##0 (work_reg_r == 8'h00 || file_wr_en_r))
        else $error("decrement to zero did not open nop slot");

    dec_no_skip_a: assert property (
        execute && instr_op == isbo_pkg::op_decrement_skip_if_zero
        && file_rd_data != isbo_pkg::DATA_ONE |=> !nop_slot)
        else $error("nonzero decrement wrongly skipped");

    inc_wrap_skip_a: assert property (
        inc_hits_zero_s |=> nop_slot ##0 $stable(zero_flag_r))
        else $error("increment wrap did not skip or touched flag");

    dest_file_write_a: assert property (
        execute && has_dest && instr_dest
        |=> file_wr_en_r && file_wr_addr_r == $past(instr_addr)
            && $stable(work_reg_r))
        else $error("file destination not honoured");

    dest_work_write_a: assert property (
        execute && instr_op == isbo_pkg::op_increment_file && !instr_dest
        |=> !file_wr_en_r
            && work_reg_r == $past(file_rd_data) + isbo_pkg::DATA_ONE)
        else $error("working destination not honoured");

    or_lit_zero_a: assert property (
        execute && instr_op == isbo_pkg::op_or_literal_into_working
        |=> zero_flag_r == (work_reg_r == 8'h00)
            && work_reg_r == ($past(work_reg_r) | $past(instr_literal[7:0])))
        else $error("literal or result or flag wrong");

    or_file_zero_a: assert property (
        execute && instr_op == isbo_pkg::op_or_working_with_file
        |=> zero_flag_r == (($past(work_reg_r) | $past(file_rd_data)) == 8'h00))
        else $error("file or zero flag wrong");

    branch_target_a: assert property (
        branch_taken_s |=> pc_r == {$past(program_counter_page_latch[4:3]),
                                    $past(instr_literal)})
        else $error("branch target wrong");

    branch_two_cyc_a: assert property (
        branch_taken_s |=> nop_slot ##0 $stable(zero_flag_r))
        else $error("branch not two cycles or flag moved");

    slot_drop_a: assert property (
        nop_slot && instr_valid
        |=> !nop_slot && $stable(zero_flag_r) && $stable(work_reg_r)
            && !file_wr_en_r)
        else $error("dropped word had an effect");

    dec_flag_keep_a: assert property (
        execute && instr_op == isbo_pkg::op_decrement_skip_if_zero
        |=> $stable(zero_flag_r))
        else $error("decrement-skip changed zero flag");

    inc_file_flag_a: assert property (
        execute && instr_op == isbo_pkg::op_increment_file
        && file_rd_data == 8'hff |=> zero_flag_r)
        else $error("increment wrap did not set zero");
endmodule // isbo_exec
`default_nettype wire

// file: verif/tb_incdec_skip_branch_or_exec.sv
`timescale 1ns/100ps
`default_nettype none
module tb_incdec_skip_branch_or_exec;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic                            core_clk;
    logic                            rst_n;
    logic                            instr_valid;
    isbo_pkg::isbo_op_t              instr_op;
    logic                            instr_dest;
    logic [isbo_pkg::ADDR_W-1:0]     instr_addr;
    logic [isbo_pkg::LIT_W-1:0]      instr_literal;
    logic [isbo_pkg::DATA_W-1:0]     file_rd_data;
    logic [isbo_pkg::DATA_W-1:0]     latch;
    logic [isbo_pkg::ADDR_W-1:0]     file_rd_addr;
    logic                            nop_slot;
    logic                            file_wr_en_r;
    logic [isbo_pkg::ADDR_W-1:0]     file_wr_addr_r;
    logic [isbo_pkg::DATA_W-1:0]     file_wr_data_r;
    logic [isbo_pkg::DATA_W-1:0]     work_reg_r;
    logic                            zero_flag_r;
    logic [isbo_pkg::PC_W-1:0]       pc_r;
    logic [isbo_pkg::PC_W-1:0]       pc_e;
    int                              fails;
    int                              compares;

    isbo_exec DUT (
        .core_clk                   (core_clk),
        .rst_n                      (rst_n),
        .instr_valid                (instr_valid),
        .instr_op                   (instr_op),
        .instr_dest                 (instr_dest),
        .instr_addr                 (instr_addr),
        .instr_literal              (instr_literal),
        .file_rd_data               (file_rd_data),
        .program_counter_page_latch (latch),
        .file_rd_addr               (file_rd_addr),
        .nop_slot                   (nop_slot),
        .file_wr_en_r               (file_wr_en_r),
        .file_wr_addr_r             (file_wr_addr_r),
        .file_wr_data_r             (file_wr_data_r),
        .work_reg_r                 (work_reg_r),
        .zero_flag_r                (zero_flag_r),
        .pc_r                       (pc_r)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Compare with case equality so an unknown never matches
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    // One word offered, then idle so results can settle
    task automatic run(input isbo_pkg::isbo_op_t op, input logic d,
                       input logic [7:0] fd, input logic [10:0] lit);
        @(posedge core_clk);
        instr_valid   <= 1'b1;
        instr_op      <= op;
        instr_dest    <= d;
        instr_addr    <= fd[6:0] ^ 7'h2A;
        file_rd_data  <= fd;
        instr_literal <= lit;
        @(posedge core_clk);
        instr_valid   <= 1'b0;
        pc_e = pc_e + 13'h0001;
        @(negedge core_clk);
        chk("rd_addr", {9'h000, fd[6:0] ^ 7'h2A}, {9'h000, file_rd_addr});
    endtask

    task automatic state(input logic [7:0] w, input logic z,
                         input logic n);
        chk("work", {8'h00, w}, {8'h00, work_reg_r});
        chk("zero", {15'h0000, z}, {15'h0000, zero_flag_r});
        chk("nop_slot", {15'h0000, n}, {15'h0000, nop_slot});
        chk("pc", {3'h0, pc_e}, {3'h0, pc_r});
    endtask

    // Write strobe, and when set the address and data it carries
    task automatic wr(input logic en, input logic [7:0] fd,
                      input logic [7:0] data);
        chk("wr_en", {15'h0000, en}, {15'h0000, file_wr_en_r});
        if (en)
        begin
            chk("wr_addr", {9'h000, fd[6:0] ^ 7'h2A},
                {9'h000, file_wr_addr_r});
            chk("wr_data", {8'h00, data}, {8'h00, file_wr_data_r});
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_or_lit();
        run(isbo_pkg::op_or_literal_into_working, 1'b1, 8'h3C, 11'h0700);
        state(8'h00, 1'b1, 1'b0);
        wr(1'b0, 8'h3C, 8'h00);
        run(isbo_pkg::op_or_literal_into_working, 1'b0, 8'h00, 11'h03A5);
        state(8'hA5, 1'b0, 1'b0);
    endtask

    task automatic t_increment_file();
        run(isbo_pkg::op_increment_file, 1'b0, 8'hFF, 11'h0000);
        state(8'h00, 1'b1, 1'b0);
        wr(1'b0, 8'hFF, 8'h00);
        run(isbo_pkg::op_increment_file, 1'b1, 8'h10, 11'h0000);
        state(8'h00, 1'b0, 1'b0);
        wr(1'b1, 8'h10, 8'h11);
    endtask

    // Zero flag is 1 going in, so any touch shows
    task automatic t_decrement_skip_if_zero();
        run(isbo_pkg::op_increment_file, 1'b0, 8'hFF, 11'h0000);
        run(isbo_pkg::op_decrement_skip_if_zero, 1'b1, 8'h02, 11'h0000);
        state(8'h00, 1'b1, 1'b0);
        wr(1'b1, 8'h02, 8'h01);
        run(isbo_pkg::op_decrement_skip_if_zero, 1'b0, 8'h00, 11'h0000);
        state(8'hFF, 1'b1, 1'b0);
        run(isbo_pkg::op_decrement_skip_if_zero, 1'b1, 8'h01, 11'h0000);
        state(8'hFF, 1'b1, 1'b1);
        wr(1'b1, 8'h01, 8'h00);
        run(isbo_pkg::op_or_literal_into_working, 1'b0, 8'h00, 11'h0000);
        state(8'hFF, 1'b1, 1'b0);
    endtask

    task automatic t_increment_skip_if_zero();
        run(isbo_pkg::op_increment_skip_if_zero, 1'b0, 8'h7F, 11'h0000);
        state(8'h80, 1'b1, 1'b0);
        run(isbo_pkg::op_increment_skip_if_zero, 1'b1, 8'hFF, 11'h0000);
        state(8'h80, 1'b1, 1'b1);
        wr(1'b1, 8'hFF, 8'h00);
        run(isbo_pkg::op_increment_file, 1'b0, 8'hFF, 11'h0000);
        state(8'h80, 1'b1, 1'b0);
    endtask

    task automatic t_or_working_with_file();
        run(isbo_pkg::op_or_working_with_file, 1'b1, 8'h01, 11'h0000);
        state(8'h80, 1'b0, 1'b0);
        wr(1'b1, 8'h01, 8'h81);
        run(isbo_pkg::op_increment_file, 1'b0, 8'hFF, 11'h0000);
        run(isbo_pkg::op_or_working_with_file, 1'b0, 8'h00, 11'h0000);
        state(8'h00, 1'b1, 1'b0);
        run(isbo_pkg::op_or_working_with_file, 1'b0, 8'h40, 11'h0000);
        state(8'h40, 1'b0, 1'b0);
        // Empty operation only steps the counter
        run(isbo_pkg::op_none, 1'b1, 8'h00, 11'h07FF);
        state(8'h40, 1'b0, 1'b0);
        wr(1'b0, 8'h00, 8'h00);
    endtask

    // Page latch noise outside bits 4:3 must not reach the counter
    task automatic t_branch(input logic [7:0] l, input logic [10:0] k);
        @(posedge core_clk);
        latch <= l;
        run(isbo_pkg::op_unconditional_branch, 1'b1, 8'h05, k);
        pc_e = {l[4:3], k};
        state(8'h40, 1'b0, 1'b1);
        wr(1'b0, 8'h05, 8'h00);
        run(isbo_pkg::op_or_literal_into_working, 1'b0, 8'h00, 11'h00FF);
        // Word dropped after a branch leaves the counter alone
        pc_e = pc_e - 13'h0001;
        state(8'h40, 1'b0, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Closing report
    // ------------------------------------------------------------
    task automatic summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Clock
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Hang guard, well beyond the scenario length
    initial
    begin
        repeat (5000) @(posedge core_clk);
        fails++;
        summarize();
    end

    // Main sequence
    initial
    begin
        fails         = 0;
        compares      = 0;
        pc_e          = 13'h0000;
        rst_n         = 1'b0;
        instr_valid   = 1'b0;
        instr_op      = isbo_pkg::op_none;
        instr_dest    = 1'b0;
        instr_addr    = 7'h00;
        instr_literal = 11'h0000;
        file_rd_data  = 8'h00;
        latch         = 8'h00;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        state(8'h00, 1'b0, 1'b0);
        wr(1'b0, 8'h00, 8'h00);
        t_or_lit();
        t_increment_file();
        t_decrement_skip_if_zero();
        t_increment_skip_if_zero();
        t_or_working_with_file();
        t_branch(8'hF8, 11'h05A5);
        t_branch(8'h08, 11'h07FF);
        summarize();
    end
endmodule // tb_incdec_skip_branch_or_exec
`default_nettype wire
